/* rtl/ps_params.svh */
// register map, reset values and timing figures of the printer status block
`ifndef PS_PARAMS_SVH
`define PS_PARAMS_SVH
`define PS_CLK_HZ      20000000
`define PS_HOLD_MS     500
`define PS_FLUSH_MS    5000
`define PS_VALVE_HZ    300
`define PS_FLASH_HZ    2
`define PS_ENC_LOSS_MS 100
`define PS_SCLK_HZ     1000000
`define PS_STEP_CYC    16
`define PS_COL_BITS    18
`define PS_COL_OFS     8'h00
`define PS_SPEED_OFS   8'h04
`define PS_RETRIP_OFS  8'h08
`define PS_STAT_OFS    8'h0c
`define PS_COL_RST     18'h00000
`define PS_SPEED_RST   16'h0000
`define PS_RETRIP_RST  16'h0000
`endif

/* rtl/ps_pkg.sv */
// types shared by the printer status block
package ps_pkg;
  typedef enum logic [6:0] {
    ST_ALL   = 7'h01,
    ST_MEM   = 7'h02,
    ST_ROM1  = 7'h04,
    ST_ROM2  = 7'h08,
    ST_INIT  = 7'h10,
    ST_TIMER = 7'h20,
    ST_DONE  = 7'h40
  } test_e;
  typedef logic [3:0] led_t;
endpackage

/* rtl/ps_column_shift.sv */
// serial column loader: shifts one column into the heads, then latches
`timescale 1ns/1ps
`include "ps_params.svh"
`default_nettype none
module ps_column_shift #(
  parameter int BITS = `PS_COL_BITS
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            tick_i,
  input  wire logic            start_i,
  input  wire logic [BITS-1:0] data_i,
  output logic                 sclk_o,
  output logic                 sdata_o,
  output logic                 latch_o,
  output logic                 busy_o
);
  logic [BITS-1:0] sh_ff;
  logic [5:0]      pulses_ff;
  logic            busy_ff;
  logic            high_ff;
  logic            latch_ff;
  wire             load = start_i && !busy_ff;
  wire             shifting = busy_ff && pulses_ff != 6'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_ff     <= '0;
      pulses_ff <= 6'h00;
      busy_ff   <= 1'b0;
      high_ff   <= 1'b0;
      latch_ff  <= 1'b0;
    end else if (load) begin
      sh_ff     <= data_i;
      pulses_ff <= 6'(BITS);
      busy_ff   <= 1'b1;
    end else if (tick_i && shifting) begin
      high_ff <= !high_ff;
      if (high_ff) begin
        sh_ff     <= {sh_ff[BITS-2:0], 1'b0};
        pulses_ff <= pulses_ff - 6'h01;
      end
    end else if (tick_i && busy_ff) begin
      latch_ff <= !latch_ff;
      busy_ff  <= !latch_ff;
    end
  end

  assign sclk_o  = high_ff;
  assign sdata_o = sh_ff[BITS-1];
  assign latch_o = latch_ff;
  assign busy_o  = busy_ff;

  latch_after_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      latch_ff |-> pulses_ff == 6'h00 && !high_ff)
    else $error("latch raised before all bits shifted");
  pulse_count_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      load |=> pulses_ff == 6'(BITS))
    else $error("column shift does not load its bit count");
endmodule // ps_column_shift
`default_nettype wire

/* rtl/ps_status.sv */
// printer logic board: indicators, self-test, flush timing, print column
// How it works
// - purge press toggles every valve drive at 300 Hz for 5 s.
// - low accumulator pressure lights the ink alarm LED.
// - during flush, flush and ink LEDs flash alternately; encoder LEDs normal.
// - yellow when encoder pulses absent, green when present.
// - self-test runs after power-up and after every reset press.
// - first step lights all four LEDs for half a second.
// - memory step shows off/yellow/red/red; green stays off afterwards.
// - first code check off/off/red/red, second off/off/off/red.
// - init step shows off/yellow/red/off, held if it fails.
// - timer interrupt step shows off/yellow/off/red.
// - end shows yellow until encoder pulses switch it to green.
// - ink-out flashes third LED, fourth off, first two encoder status.
// - reset press clears the registers and working state.
// - one column is shifted with exactly 18 serial clock pulses.
// - data latch follows the shifted column.
// - print request pulses whenever a column is ready to print.
// - jumper picks external encoder or internal fixed-rate pulses.
// - jumper picks external sensor or simulated repeating trigger.
// - printing starts a thumbwheel count of encoder pulses after the edge.
`timescale 1ns/1ps
`include "ps_params.svh"
`default_nettype none
module ps_status import ps_pkg::*; #(
  parameter int HEADS     = 4,
  parameter int DLY_W     = 12,
  parameter int HOLD_CYC  = `PS_CLK_HZ / 1000 * `PS_HOLD_MS,
  parameter int FLUSH_CYC = `PS_CLK_HZ / 1000 * `PS_FLUSH_MS,
  parameter int VALVE_CYC = `PS_CLK_HZ / (2 * `PS_VALVE_HZ),
  parameter int FLASH_CYC = `PS_CLK_HZ / (2 * `PS_FLASH_HZ),
  parameter int LOSS_CYC  = `PS_CLK_HZ / 1000 * `PS_ENC_LOSS_MS,
  parameter int MS_CYC    = `PS_CLK_HZ / 1000
) (
  input  wire logic             CLK_SYS_I,
  input  wire logic             SYS_RST_I,
  input  wire logic             HSEL_I,
  input  wire logic [31:0]      HADDR_I,
  input  wire logic [1:0]       HTRANS_I,
  input  wire logic             HWRITE_I,
  input  wire logic [2:0]       HSIZE_I,
  input  wire logic [31:0]      HWDATA_I,
  input  wire logic             HREADY_I,
  output logic      [31:0]      HRDATA_O,
  output logic                  HREADYOUT_O,
  output logic                  HRESP_O,
  input  wire logic             LINE_SPEED_PULSES_I,
  input  wire logic             PRODUCT_DETECT_N_I,
  input  wire logic             INK_ALARM_I,
  input  wire logic             PURGE_SW_I,
  input  wire logic             RESET_SW_I,
  input  wire logic             SPEED_SOURCE_JUMPER_I,
  input  wire logic             SIMULATED_TRIGGER_SELECT_I,
  input  wire logic [DLY_W-1:0] DELAY_SW_I,
  input  wire logic [4:0]       STEP_FAIL_I,
  output logic                  LED_RUN_O,
  output logic                  LED_STOP_O,
  output logic                  LED_INK_O,
  output logic                  LED_FLUSH_O,
  output logic      [HEADS-1:0] VALVE_O,
  output logic                  PRINT_REQUEST_PULSE_O,
  output logic                  SERIAL_PRINT_BITS_O,
  output logic                  SERIAL_CLK_O,
  output logic                  DATA_LATCH_O
);
  // seven single pins, five step-fail pins, then the thumbwheels
  localparam int SW = DLY_W + 12;
  localparam int STEP_CYC = `PS_STEP_CYC;
  localparam int SCLK_CYC = `PS_CLK_HZ / (2 * `PS_SCLK_HZ);

  // pins from outside: two flops before any logic looks at them
  logic [SW-1:0] meta_ff;
  logic [SW-1:0] sync_ff;
  logic [3:0]    prev_ff;
  wire  [SW-1:0] pins = {DELAY_SW_I, STEP_FAIL_I, SIMULATED_TRIGGER_SELECT_I,
                         SPEED_SOURCE_JUMPER_I, INK_ALARM_I, RESET_SW_I,
                         PURGE_SW_I, PRODUCT_DETECT_N_I, LINE_SPEED_PULSES_I};
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= 4'h0;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff[3:0];
    end
  end
  wire             enc_pin   = sync_ff[0];
  wire             product_detect_input_n   = sync_ff[1];
  wire             ink_low   = sync_ff[4];
  wire             int_speed = sync_ff[5];
  wire             sim_print_request_pulse  = sync_ff[6];
  wire [4:0]       step_fail = sync_ff[11:7];
  wire [DLY_W-1:0] delay_sw  = sync_ff[SW-1:12];
  wire ext_enc_rise = enc_pin && !prev_ff[0];
  wire ext_trip     = !product_detect_input_n && prev_ff[1];
  wire purge_press  = sync_ff[2] && !prev_ff[2];
  wire soft_clr     = sync_ff[3] && !prev_ff[3];

  // registers
  logic [`PS_COL_BITS-1:0] col_ff;
  logic [15:0]             speed_ff;
  logic [15:0]             retrip_ff;
  logic [7:0]              addr_ff;
  logic                    wr_ff;
  logic [31:0]             rdata_ff;
  logic [31:0]             stat_w;
  wire addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire [7:0] a_ofs = {HADDR_I[7:2], 2'b00};
  wire hit_col    = addr_ff == `PS_COL_OFS;
  wire hit_speed  = addr_ff == `PS_SPEED_OFS;
  wire hit_retrip = addr_ff == `PS_RETRIP_OFS;
  wire in_map     = HADDR_I[31:8] == 24'h000000;
  wire [31:0] rd_mux =
    !in_map                   ? 32'h00000000 :
    a_ofs == `PS_COL_OFS      ? {14'h0000, col_ff} :
    a_ofs == `PS_SPEED_OFS    ? {16'h0000, speed_ff} :
    a_ofs == `PS_RETRIP_OFS   ? {16'h0000, retrip_ff} :
    a_ofs == `PS_STAT_OFS     ? stat_w : 32'h00000000;

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      addr_ff  <= 8'hff;
      wr_ff    <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_ff    <= addr_phase && HWRITE_I && in_map;
      addr_ff  <= a_ofs;
      if (addr_phase && !HWRITE_I)
        rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      col_ff    <= `PS_COL_RST;
      speed_ff  <= `PS_SPEED_RST;
      retrip_ff <= `PS_RETRIP_RST;
    end else if (soft_clr) begin
      col_ff    <= `PS_COL_RST;
      speed_ff  <= `PS_SPEED_RST;
      retrip_ff <= `PS_RETRIP_RST;
    end else if (wr_ff) begin
      if (hit_col)
        col_ff <= HWDATA_I[`PS_COL_BITS-1:0];
      if (hit_speed)
        speed_ff <= HWDATA_I[15:0];
      if (hit_retrip)
        retrip_ff <= HWDATA_I[15:0];
    end
  end
  assign HRDATA_O    = rdata_ff;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // self-test sequencer
  test_e       test_ff;
  test_e       nxt_test;
  logic [31:0] step_cnt_ff;
  logic        halted_ff;
  wire [31:0] step_len = test_ff == ST_ALL ? 32'(HOLD_CYC) : 32'(STEP_CYC);
  wire        step_end = test_ff != ST_DONE && !halted_ff
                         && step_cnt_ff == step_len - 32'h1;
  logic       step_bad;
  always_comb begin
    nxt_test = test_ff;
    step_bad = 1'b0;
    unique case (test_ff)
      ST_ALL:   nxt_test = ST_MEM;
      ST_MEM:   begin nxt_test = ST_ROM1;  step_bad = step_fail[0]; end
      ST_ROM1:  begin nxt_test = ST_ROM2;  step_bad = step_fail[1]; end
      ST_ROM2:  begin nxt_test = ST_INIT;  step_bad = step_fail[2]; end
      ST_INIT:  begin nxt_test = ST_TIMER; step_bad = step_fail[3]; end
      ST_TIMER: begin nxt_test = ST_DONE;  step_bad = step_fail[4]; end
      ST_DONE:  nxt_test = ST_DONE;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      test_ff     <= ST_ALL;
      step_cnt_ff <= 32'h0;
      halted_ff   <= 1'b0;
    end else if (soft_clr) begin
      test_ff     <= ST_ALL;
      step_cnt_ff <= 32'h0;
      halted_ff   <= 1'b0;
    end else if (step_end) begin
      halted_ff   <= step_bad;
      test_ff     <= step_bad ? test_ff : nxt_test;
      step_cnt_ff <= 32'h0;
    end else if (test_ff != ST_DONE && !halted_ff) begin
      step_cnt_ff <= step_cnt_ff + 32'h1;
    end
  end
  wire done = test_ff == ST_DONE;

  // slow flash phase and millisecond tick
  logic [31:0] flash_cnt_ff;
  logic        flash_ff;
  logic [31:0] ms_cnt_ff;
  wire         ms_tick = ms_cnt_ff == 32'(MS_CYC - 1);
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      flash_cnt_ff <= 32'h0;
      flash_ff     <= 1'b0;
      ms_cnt_ff    <= 32'h0;
    end else begin
      flash_cnt_ff <= flash_cnt_ff == 32'(FLASH_CYC - 1) ? 32'h0
                    : flash_cnt_ff + 32'h1;
      if (flash_cnt_ff == 32'(FLASH_CYC - 1))
        flash_ff <= !flash_ff;
      ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
    end
  end

  // line speed source and encoder presence
  logic [15:0] gen_cnt_ff;
  logic [31:0] loss_cnt_ff;
  logic        present_ff;
  wire gen_tick = speed_ff != 16'h0000 && gen_cnt_ff == speed_ff - 16'h1;
  wire enc_tick = int_speed ? gen_tick : ext_enc_rise;
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      gen_cnt_ff  <= 16'h0;
      loss_cnt_ff <= 32'h0;
      present_ff  <= 1'b0;
    end else begin
      gen_cnt_ff <= gen_tick || speed_ff == 16'h0000 ? 16'h0
                  : gen_cnt_ff + 16'h1;
      if (enc_tick) begin
        loss_cnt_ff <= 32'h0;
        present_ff  <= 1'b1;
      end else if (loss_cnt_ff == 32'(LOSS_CYC - 1)) begin
        present_ff  <= 1'b0;
      end else begin
        loss_cnt_ff <= loss_cnt_ff + 32'h1;
      end
    end
  end

  // product detection, print delay and column dispatch
  logic [15:0]      retrip_cnt_ff;
  logic [DLY_W-1:0] dly_ff;
  logic             waiting_ff;
  logic             print_request_pulse_ff;
  logic             sclk_tick;
  logic [7:0]       sclk_cnt_ff;
  logic             shift_busy;
  wire sim_tick = retrip_ff != 16'h0000 && ms_tick
                  && retrip_cnt_ff == retrip_ff - 16'h1;
  wire product_edge = sim_print_request_pulse ? sim_tick : ext_trip;
  wire fire = done && waiting_ff && dly_ff == '0 && !shift_busy;
  assign sclk_tick = sclk_cnt_ff == 8'(SCLK_CYC - 1);
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      retrip_cnt_ff <= 16'h0;
      dly_ff        <= '0;
      waiting_ff    <= 1'b0;
      print_request_pulse_ff       <= 1'b0;
      sclk_cnt_ff   <= 8'h0;
    end else begin
      sclk_cnt_ff <= sclk_tick ? 8'h0 : sclk_cnt_ff + 8'h1;
      if (ms_tick)
        retrip_cnt_ff <= sim_tick || retrip_ff == 16'h0000 ? 16'h0
                       : retrip_cnt_ff + 16'h1;
      print_request_pulse_ff <= fire;
      if (soft_clr) begin
        waiting_ff <= 1'b0;
      end else if (product_edge && done) begin
        dly_ff     <= delay_sw;
        waiting_ff <= 1'b1;
      end else if (fire) begin
        waiting_ff <= 1'b0;
      end else if (waiting_ff && enc_tick && dly_ff != '0) begin
        dly_ff <= dly_ff - {{(DLY_W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign PRINT_REQUEST_PULSE_O = print_request_pulse_ff;

  ps_column_shift #(
    .BITS (`PS_COL_BITS)
  ) u_shift (
    .clk_i   (CLK_SYS_I),
    .rst_i   (SYS_RST_I),
    .tick_i  (sclk_tick),
    .start_i (print_request_pulse_ff),
    .data_i  (col_ff),
    .sclk_o  (SERIAL_CLK_O),
    .sdata_o (SERIAL_PRINT_BITS_O),
    .latch_o (DATA_LATCH_O),
    .busy_o  (shift_busy)
  );

  // flush cycle
  logic        flushing_ff;
  logic [31:0] flush_cnt_ff;
  logic [31:0] valve_cnt_ff;
  logic        valve_ff;
  wire valve_flip = valve_cnt_ff == 32'(VALVE_CYC - 1);
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      flushing_ff  <= 1'b0;
      flush_cnt_ff <= 32'h0;
      valve_cnt_ff <= 32'h0;
      valve_ff     <= 1'b0;
    end else if (soft_clr) begin
      flushing_ff <= 1'b0;
      valve_ff    <= 1'b0;
    end else if (!flushing_ff) begin
      flushing_ff  <= purge_press && done;
      flush_cnt_ff <= 32'h0;
      valve_cnt_ff <= 32'h0;
    end else begin
      // 300 Hz for the flush time
      flush_cnt_ff <= flush_cnt_ff + 32'h1;
      valve_cnt_ff <= valve_flip ? 32'h0 : valve_cnt_ff + 32'h1;
      valve_ff     <= valve_flip ? !valve_ff : valve_ff;
      if (flush_cnt_ff == 32'(FLUSH_CYC - 1)) begin
        flushing_ff <= 1'b0;
        valve_ff    <= 1'b0;
      end
    end
  end
  assign VALVE_O = {HEADS{valve_ff}};

  // indicators: green, yellow, ink red, flush red
  led_t leds;
  wire led_t test_leds =
    test_ff == ST_ALL  ? 4'hf : test_ff == ST_MEM   ? 4'h7 :
    test_ff == ST_ROM1 ? 4'h3 : test_ff == ST_ROM2  ? 4'h1 :
    test_ff == ST_INIT ? 4'h6 : test_ff == ST_TIMER ? 4'h5 : 4'h4;
  wire led_t run_leds = {present_ff, !present_ff,
                         (flushing_ff || ink_low) && flash_ff,
                         flushing_ff && !flash_ff};
  assign leds        = done ? run_leds : test_leds;
  assign LED_RUN_O   = leds[3];
  assign LED_STOP_O  = leds[2];
  assign LED_INK_O   = leds[1];
  assign LED_FLUSH_O = leds[0];
  assign stat_w = {15'h0000, halted_ff, 1'b0, test_ff, flushing_ff,
                   present_ff, shift_busy, waiting_ff, leds};

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  flush_end_a:
    assert property (flushing_ff && flush_cnt_ff == 32'(FLUSH_CYC - 1)
                     |=> !flushing_ff && !valve_ff)
    else $error("flush did not stop at its time");
  valve_rate_a:
    assert property (flushing_ff && !valve_flip && !soft_clr
                     && flush_cnt_ff != 32'(FLUSH_CYC - 1)
                     |=> $stable(valve_ff))
    else $error("valve toggled off its rate");
  ink_flash_a:
    assert property (done && !flushing_ff && ink_low
                     |-> LED_INK_O == flash_ff && !LED_FLUSH_O)
    else $error("ink alarm indication wrong");
  flush_alt_a:
    assert property (done && flushing_ff |-> LED_INK_O != LED_FLUSH_O)
    else $error("flush LEDs not alternating");
  enc_leds_a:
    assert property (done |-> LED_RUN_O == present_ff
                     && LED_STOP_O == !present_ff)
    else $error("encoder LEDs wrong");
  restart_a:
    assert property (soft_clr |=> test_ff == ST_ALL && col_ff == '0)
    else $error("reset press did not restart self-test");
  all_on_a:
    assert property ($rose(test_ff == ST_MEM)
                     |-> $past(test_ff == ST_ALL) && $past(leds) == 4'hf)
    else $error("all-on step not shown");
  green_off_a:
    assert property (!done && test_ff != ST_ALL |-> !LED_RUN_O)
    else $error("green on during self-test");
  fail_hold_a:
    assert property (halted_ff && !soft_clr |=> $stable(test_ff) && halted_ff)
    else $error("failed step did not hold");
endmodule // ps_status
`default_nettype wire

/* tb/ps_far_side.sv */
// far side model: conveyor encoder and print heads
`timescale 1ns/1ps
`default_nettype none
module ps_far_side (
  input  wire logic        enc_on_i,
  input  wire logic        sclk_i,
  input  wire logic        sdata_i,
  input  wire logic        latch_i,
  output logic             enc_o,
  output logic [17:0]      col_o,
  output logic [7:0]       cnt_o
);
  logic [17:0] sh_ff;
  logic [7:0]  n_ff = 8'h00;
  // encoder idles low outside bursts, 400 ns period inside
  initial begin
    enc_o = 1'b0;
    forever #200 enc_o = enc_on_i & ~enc_o;
  end
  // heads shift on clock rise and fire from the latched bits
  always @(posedge sclk_i or posedge latch_i) begin
    if (latch_i) begin
      col_o <= sh_ff;
      cnt_o <= n_ff;
      n_ff <= 8'h00;
    end else begin
      sh_ff <= {sh_ff[16:0], sdata_i};
      n_ff <= n_ff + 8'h01;
    end
  end
endmodule // ps_far_side
`default_nettype wire

/* tb/ps_status_test.sv */
// self-checking bench of the printer status block
`timescale 1ns/1ps
`default_nettype none
module ps_status_test;
  import ps_pkg::*;
  localparam int HOLD = 20;
  localparam int FLUSH = 2000;
  localparam int VALVE = 10;
  localparam int FLASH = 8;
  localparam int LOSS = 100;
  localparam int DLY = 12;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, enc_on = 0;
  logic        pdet_n = 1, ink = 0, rst_sw = 0, purge = 0;
  logic        sp_j = 0, tr_j = 0;
  logic [11:0] dly = 12'(DLY);
  logic [4:0]  fail = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, d;
  logic        hready, run, stop, inkl, fl, req, sd, sclk, latch, line_speed_pulses;
  logic [3:0]  valve;
  logic [17:0] col;
  logic [7:0]  cnt;
  wire  [3:0]  leds = {run, stop, inkl, fl};
  logic [3:0]  pats [7] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h6, 4'h5, 4'h4};
  int failures = 0, comparisons = 0, cyc = 0, reqs = 0, seed = 32'h9fb002fe;
  int i, c, t, m, f, r0;

  ps_status #(.HOLD_CYC(HOLD), .FLUSH_CYC(FLUSH), .VALVE_CYC(VALVE),
    .FLASH_CYC(FLASH), .LOSS_CYC(LOSS), .MS_CYC(4)) dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(), .LINE_SPEED_PULSES_I(line_speed_pulses),
    .PRODUCT_DETECT_N_I(pdet_n), .INK_ALARM_I(ink), .PURGE_SW_I(purge),
    .RESET_SW_I(rst_sw), .SPEED_SOURCE_JUMPER_I(sp_j),
    .SIMULATED_TRIGGER_SELECT_I(tr_j), .DELAY_SW_I(dly),
    .STEP_FAIL_I(fail), .LED_RUN_O(run), .LED_STOP_O(stop),
    .LED_INK_O(inkl), .LED_FLUSH_O(fl), .VALVE_O(valve),
    .PRINT_REQUEST_PULSE_O(req), .SERIAL_PRINT_BITS_O(sd),
    .SERIAL_CLK_O(sclk), .DATA_LATCH_O(latch));

  ps_far_side far (.enc_on_i(enc_on), .sclk_i(sclk), .sdata_i(sd),
    .latch_i(latch), .enc_o(line_speed_pulses), .col_o(col), .cnt_o(cnt));

  initial begin
    forever #25 clk = ~clk;
  end

  // switches and the photocell are one-cycle presses
  always @(posedge clk) begin
    cyc++;
    if (rst_sw) rst_sw <= 1'b0;
    if (purge) purge <= 1'b0;
    if (!pdet_n) pdet_n <= 1'b1;
    if (cyc == 20000) begin
      failures++;
      print_verdict;
    end
  end

  // the request is a one-cycle flop output: count it where it is settled
  always @(negedge clk) begin
    if (req === 1'b1) reqs++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // step patterns sampled mid-step; a failed step freezes
  task selftest(input int fs);
    repeat (10) @(posedge clk);
    chk(leds, pats[0]);
    repeat (HOLD - 18) @(posedge clk);
    for (int k = 1; k < 7; k++) begin
      repeat (16) @(posedge clk);
      chk(leds, pats[k > fs + 1 ? fs + 1 : k]);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    selftest(5);
    bus(0, 32'h0c, 0);
    chk(q, 32'h00004004);
    d = $random(seed);
    bus(1, 32'h0, d);
    bus(0, 32'h0, 0);
    chk(q, {14'h0, d[17:0]});
    bus(1, 32'h10, d);
    bus(0, 32'h10, 0);
    chk(q, 0);
    $display("test selftest and registers done");
    // random failing step holds its pattern
    f = {$random(seed)} % 5;
    fail <= 5'h1 << f;
    @(posedge clk);
    rst_sw <= 1'b1;
    selftest(f);
    repeat (200) @(posedge clk);
    chk(leds, pats[f + 1]);
    fail <= 5'h0;
    rst_sw <= 1'b1;
    selftest(5);
    bus(0, 32'h0, 0);
    chk(q, 0);
    $display("test failed step and reset switch done");
    bus(1, 32'h0, d);
    enc_on = 1'b1;
    repeat (60) @(posedge clk);
    chk(leds, 4'h8);
    pdet_n <= 1'b0;
    for (c = 0; c < 500 && req !== 1'b1; c++) @(negedge clk);
    chk(32'(c >= (DLY - 1) * 8 && c <= DLY * 8 + 8), 1);
    for (i = 0; i < 2000 && latch !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(cnt, 18);
    chk(col, d[17:0]);
    chk(reqs, 1);
    enc_on = 1'b0;
    repeat (LOSS + 50) @(posedge clk);
    chk(leds, 4'h4);
    $display("test print column done");
    ink <= 1'b1;
    repeat (10) @(negedge clk);
    t = 0;
    m = 0;
    r0 = inkl;
    for (i = 0; i < 8 * FLASH; i++) begin
      @(negedge clk);
      if (inkl !== r0[0]) t++;
      if (fl !== 1'b0) m++;
      r0 = inkl;
    end
    chk(t, 8);
    chk(m, 0);
    $display("test ink alarm done");
    @(posedge clk);
    ink <= 1'b0;
    purge <= 1'b1;
    t = 0;
    m = 0;
    r0 = valve[0];
    for (i = 0; i < FLUSH + 50; i++) begin
      @(negedge clk);
      if (valve[0] !== r0[0]) t++;
      if (valve !== {4{valve[0]}}) m++;
      if (i >= 10 && i < FLUSH && inkl === fl) m++;
      r0 = valve[0];
    end
    chk(t, FLUSH / VALVE);
    chk(m, 0);
    chk(valve, 0);
    $display("test flush done");
    // internal generator alone must light green with the encoder stopped
    bus(1, 32'h4, 32'h10);
    sp_j <= 1'b1;
    repeat (60) @(posedge clk);
    chk(leds, 4'h8);
    r0 = reqs;
    bus(1, 32'h8, 32'h64);
    tr_j <= 1'b1;
    for (i = 0; i < 3000 && reqs == r0; i++) @(negedge clk);
    chk(32'(reqs > r0), 1);
    $display("test internal sources done");
    print_verdict;
  end
endmodule // ps_status_test
`default_nettype wire
